// *** src/serial_handshake.sv ***
// Operation
// RL1: Control word: toggles, reinit, tx length
// RL2: Status word: toggles, done, full, rx length
// RL3: Tx toggle change sends tx_length bytes
// RL4: Invert tx_done_toggle once bytes taken
// RL5: Controller waits tx_done_toggle before retoggling
// RL6: Load rx array, length, invert rx_valid_toggle
// RL7: Controller inverts rx_ack_toggle after reading
// RL8: No new rx copy before acknowledge
// RL9: Reinit rising edge blocks, clears buffers
// RL10: Set reinit_done when reinit finished
// RL11: Controller drops request after reinit_done
// RL12: Clear reinit_done when request withdrawn
// RL13: Full flag set, bytes dropped while full
// RL14: Compare copies each clock, reset on reinit
// RL15: Ignore toggles while reinit requested
`default_nettype none
module serial_handshake (
    input  wire logic        clk_sys,
    input  wire logic        reset,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             irq,
    output logic      [7:0]  tx_byte,
    output logic             tx_valid,
    input  wire logic        tx_ready,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_valid
);
    // Register state
    logic [15:0] serial_control_word, next_serial_control_word;
    logic [7:0]  tx_bytes [serial_handshake_pkg::ARRAY_BYTES];  // Transmit data array
    logic [7:0]  rx_bytes [serial_handshake_pkg::ARRAY_BYTES];  // Receive data array
    logic [serial_handshake_pkg::IRQ_W-1:0] irq_status, next_irq_status;
    logic [serial_handshake_pkg::IRQ_W-1:0] irq_mask, next_irq_mask;
    // Handshake state
    logic        tx_toggle_seen, next_tx_toggle_seen;   // Stored copy of control bit 0
    logic        ack_seen, next_ack_seen;               // Stored copy of control bit 1
    logic        reinit_seen, next_reinit_seen;         // Previous reinit request
    logic        tx_done_toggle, next_tx_done_toggle;
    logic        rx_valid_toggle, next_rx_valid_toggle;
    logic        rx_owned, next_rx_owned;               // Array handed to controller
    logic        reinit_done, next_reinit_done;
    logic [11:0] rx_length, next_rx_length;
    // Transmit engine
    serial_handshake_pkg::tx_state_type tx_state, next_tx_state;
    logic [11:0] tx_count, next_tx_count, tx_total, next_tx_total;
    // Reinit sequencer
    serial_handshake_pkg::ri_state_type ri_state, next_ri_state;
    logic [3:0]  ri_count, next_ri_count;
    // Receive FIFO
    logic [7:0]  fifo_mem [serial_handshake_pkg::FIFO_DEPTH];
    logic [4:0]  wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
    logic        fifo_full, fifo_empty, fifo_push, fifo_pop;
    logic [7:0]  fifo_head;

    // Word index of an array address, shared by both arrays
    function automatic logic [3:0] word_index(input logic [7:0] a);
        word_index = a[5:2];
    endfunction

    logic        bus_wr, bus_rd, tx_hit, rx_hit;
    logic [3:0]  widx;
    logic [31:0] next_prdata;  // Read data picked in the setup cycle
    logic        reinit_req, tx_event, ack_event, blocked;
    assign widx   = word_index(paddr);
    assign bus_wr = psel && penable && pwrite && clk_en;
    assign bus_rd = psel && !penable && !pwrite;
    assign tx_hit = (paddr[7:6] == serial_handshake_pkg::ADDR_TX_BASE[7:6]);
    assign rx_hit = (paddr[7:6] == serial_handshake_pkg::ADDR_RX_BASE[7:6]);
    // Zero wait states; stalls while clock enable is low
    assign pready  = clk_en;
    assign pslverr = 1'b0;

    // RL1 control fields
    assign reinit_req = serial_control_word[serial_handshake_pkg::BIT_REINIT];
    // RL14 compare with copies
    assign tx_event  = serial_control_word[serial_handshake_pkg::BIT_TOGGLE_A] != tx_toggle_seen;
    assign ack_event = serial_control_word[serial_handshake_pkg::BIT_TOGGLE_B] != ack_seen;
    // RL9 block exchange
    assign blocked = reinit_req || (ri_state != serial_handshake_pkg::RI_RUN);

    // FIFO flags; pointers carry one wrap bit for honest full
    assign fifo_empty = (wr_ptr == rd_ptr);
    assign fifo_full  = (wr_ptr[3:0] == rd_ptr[3:0]) && (wr_ptr[4] != rd_ptr[4]);
    // RL13 drop while full
    assign fifo_push  = rx_valid && !fifo_full && !blocked;
    assign fifo_head  = fifo_mem[rd_ptr[3:0]];

    // Read mux, taken in setup so read data leave a flip-flop with no wait state
    always_comb
    begin
        next_prdata = 32'h0000_0000;
        if (bus_rd)
        begin
            if (paddr == serial_handshake_pkg::ADDR_CONTROL)
                next_prdata = {16'h0000, serial_control_word};
            // RL2 status layout
            else if (paddr == serial_handshake_pkg::ADDR_STATUS)
                next_prdata = {16'h0000, rx_length, fifo_full, reinit_done,
                               rx_valid_toggle, tx_done_toggle};
            else if (paddr == serial_handshake_pkg::ADDR_IRQ_STS)
                next_prdata = {28'h0000000, irq_status};
            else if (paddr == serial_handshake_pkg::ADDR_IRQ_MSK)
                next_prdata = {28'h0000000, irq_mask};
            else if (tx_hit)
                next_prdata = {24'h000000, tx_bytes[widx]};
            else if (rx_hit)
                next_prdata = {24'h000000, rx_bytes[widx]};
        end
    end

    // Level interrupt from unmasked sticky bits
    assign irq = |(irq_status & irq_mask);

    // Control, handshake and sequencing next values
    always_comb
    begin
        next_serial_control_word = serial_control_word;
        next_irq_mask        = irq_mask;
        next_irq_status      = irq_status;
        next_tx_toggle_seen  = tx_toggle_seen;
        next_ack_seen        = ack_seen;
        next_reinit_seen     = reinit_req;
        next_tx_done_toggle  = tx_done_toggle;
        next_rx_valid_toggle = rx_valid_toggle;
        next_rx_owned        = rx_owned;
        next_reinit_done     = reinit_done;
        next_rx_length       = rx_length;
        next_tx_state        = tx_state;
        next_tx_count        = tx_count;
        next_tx_total        = tx_total;
        next_ri_state        = ri_state;
        next_ri_count        = ri_count;
        next_rd_ptr          = rd_ptr;
        next_wr_ptr          = fifo_push ? wr_ptr + 5'd1 : wr_ptr;
        fifo_pop             = 1'b0;
        // Software writes to control and mask
        if (bus_wr && paddr == serial_handshake_pkg::ADDR_CONTROL)
            next_serial_control_word = pwdata[15:0];
        if (bus_wr && paddr == serial_handshake_pkg::ADDR_IRQ_MSK)
            next_irq_mask = pwdata[serial_handshake_pkg::IRQ_W-1:0];
        // Write one to clear; events below win over the clear
        if (bus_wr && paddr == serial_handshake_pkg::ADDR_IRQ_STS)
            next_irq_status = irq_status & ~pwdata[serial_handshake_pkg::IRQ_W-1:0];
        if (fifo_full)
            next_irq_status[serial_handshake_pkg::IRQ_FULL] = 1'b1;
        // RL15 toggles ignored
        if (!blocked)
        begin
            // Transmit engine
            case (tx_state)
                serial_handshake_pkg::TX_IDLE:
                begin
                    // RL3 start on toggle
                    if (tx_event)
                    begin
                        next_tx_toggle_seen = ~tx_toggle_seen;
                        next_tx_count = 12'h000;
                        next_tx_total = serial_control_word[15:4];
                        next_tx_state = (serial_control_word[15:4] == 12'h000) ?
                            serial_handshake_pkg::TX_ACK : serial_handshake_pkg::TX_SEND;
                    end
                end
                serial_handshake_pkg::TX_SEND:
                begin
                    if (tx_ready)
                    begin
                        next_tx_count = tx_count + 12'h001;
                        if (tx_count + 12'h001 >= tx_total)
                            next_tx_state = serial_handshake_pkg::TX_ACK;
                    end
                end
                serial_handshake_pkg::TX_ACK:
                begin
                    // RL4 acknowledge transmit
                    next_tx_done_toggle = ~tx_done_toggle;
                    next_irq_status[serial_handshake_pkg::IRQ_TX_DONE] = 1'b1;
                    next_tx_state = serial_handshake_pkg::TX_IDLE;
                end
                default:
                    next_tx_state = serial_handshake_pkg::TX_IDLE;
            endcase
            // RL8 release after acknowledge
            if (ack_event)
            begin
                next_ack_seen = ~ack_seen;
                next_rx_owned = 1'b0;
            end
            // RL6 hand over received bytes
            else if (!rx_owned && !fifo_empty)
            begin
                next_rx_length = {7'h00, 5'(wr_ptr - rd_ptr)};
                next_rd_ptr = wr_ptr;
                fifo_pop = 1'b1;
                next_rx_valid_toggle = ~rx_valid_toggle;
                next_rx_owned = 1'b1;
                next_irq_status[serial_handshake_pkg::IRQ_RX_VALID] = 1'b1;
            end
        end
        // Reinit sequencer
        case (ri_state)
            serial_handshake_pkg::RI_RUN:
            begin
                // RL9 rising edge
                if (reinit_req && !reinit_seen)
                begin
                    next_ri_state = serial_handshake_pkg::RI_CLEAR;
                    next_ri_count = 4'h0;
                end
            end
            serial_handshake_pkg::RI_CLEAR:
            begin
                // RL14 reset copies and toggles
                next_tx_toggle_seen  = 1'b0;
                next_ack_seen        = 1'b0;
                next_tx_done_toggle  = 1'b0;
                next_rx_valid_toggle = 1'b0;
                next_rx_owned        = 1'b0;
                next_rx_length       = 12'h000;
                next_tx_state        = serial_handshake_pkg::TX_IDLE;
                next_wr_ptr          = 5'd0;
                next_rd_ptr          = 5'd0;
                next_ri_count        = ri_count + 4'h1;
                if (ri_count == 4'(serial_handshake_pkg::REINIT_CYCLES - 1))
                begin
                    // RL10 report completion
                    next_reinit_done = 1'b1;
                    next_irq_status[serial_handshake_pkg::IRQ_REINIT] = 1'b1;
                    next_ri_state = serial_handshake_pkg::RI_DONE;
                end
            end
            serial_handshake_pkg::RI_DONE:
            begin
                // RL12 resume on withdraw
                if (!reinit_req)
                begin
                    next_reinit_done = 1'b0;
                    next_ri_state = serial_handshake_pkg::RI_RUN;
                    // Controller bits are the new reference after reinit
                    next_tx_toggle_seen = serial_control_word[serial_handshake_pkg::BIT_TOGGLE_A];
                    next_ack_seen = serial_control_word[serial_handshake_pkg::BIT_TOGGLE_B];
                end
            end
            default:
                next_ri_state = serial_handshake_pkg::RI_RUN;
        endcase
    end

    // Transmit byte output is registered from the array
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            tx_byte  <= 8'h00;
            tx_valid <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_valid <= (next_tx_state == serial_handshake_pkg::TX_SEND);
            tx_byte  <= tx_bytes[next_tx_count[3:0]];
        end
    end

    // Arrays: software fills transmit, FIFO drains into receive
    always_ff @(posedge clk_sys)
    begin
        if (clk_en)
        begin
            if (bus_wr && tx_hit)
                tx_bytes[widx] <= pwdata[7:0];
            if (fifo_push)
                fifo_mem[wr_ptr[3:0]] <= rx_byte;
            if (fifo_pop)
            begin
                for (int i = 0; i < serial_handshake_pkg::ARRAY_BYTES; i++)
                    rx_bytes[i] <= fifo_mem[4'(rd_ptr[3:0] + 4'(i))];
            end
        end
    end

    // Register all control state
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            serial_control_word <= 16'h0000;
            prdata          <= 32'h0000_0000;
            irq_status      <= 4'h0;
            irq_mask        <= 4'h0;
            tx_toggle_seen  <= 1'b0;
            ack_seen        <= 1'b0;
            reinit_seen     <= 1'b0;
            tx_done_toggle  <= 1'b0;
            rx_valid_toggle <= 1'b0;
            rx_owned        <= 1'b0;
            reinit_done     <= 1'b0;
            rx_length       <= 12'h000;
            tx_state        <= serial_handshake_pkg::TX_IDLE;
            tx_count        <= 12'h000;
            tx_total        <= 12'h000;
            ri_state        <= serial_handshake_pkg::RI_RUN;
            ri_count        <= 4'h0;
            wr_ptr          <= 5'd0;
            rd_ptr          <= 5'd0;
        end
        else if (clk_en)
        begin
            serial_control_word <= next_serial_control_word;
            prdata          <= next_prdata;
            irq_status      <= next_irq_status;
            irq_mask        <= next_irq_mask;
            tx_toggle_seen  <= next_tx_toggle_seen;
            ack_seen        <= next_ack_seen;
            reinit_seen     <= next_reinit_seen;
            tx_done_toggle  <= next_tx_done_toggle;
            rx_valid_toggle <= next_rx_valid_toggle;
            rx_owned        <= next_rx_owned;
            reinit_done     <= next_reinit_done;
            rx_length       <= next_rx_length;
            tx_state        <= next_tx_state;
            tx_count        <= next_tx_count;
            tx_total        <= next_tx_total;
            ri_state        <= next_ri_state;
            ri_count        <= next_ri_count;
            wr_ptr          <= next_wr_ptr;
            rd_ptr          <= next_rd_ptr;
        end
    end
endmodule
`default_nettype wire

// *** src/serial_handshake_pkg.sv ***
`default_nettype none
package serial_handshake_pkg;
    // Register byte offsets on APB
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STS = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MSK = 8'h0C;
    localparam logic [7:0] ADDR_TX_BASE = 8'h40;
    localparam logic [7:0] ADDR_RX_BASE = 8'h80;
    // Control and status word field positions
    localparam int BIT_TOGGLE_A = 0;
    localparam int BIT_TOGGLE_B = 1;
    localparam int BIT_REINIT   = 2;
    localparam int BIT_FULL     = 3;
    localparam int LEN_LSB      = 4;
    localparam int LEN_W        = 12;
    // Data array depth in bytes and FIFO depth
    localparam int ARRAY_BYTES  = 16;
    localparam int ARRAY_AW     = 4;
    localparam int FIFO_DEPTH   = 16;
    localparam int FIFO_AW      = 4;
    // Interrupt status bits
    localparam int IRQ_TX_DONE  = 0;
    localparam int IRQ_RX_VALID = 1;
    localparam int IRQ_REINIT   = 2;
    localparam int IRQ_FULL     = 3;
    localparam int IRQ_W        = 4;
    // Reinit takes a short fixed settle time
    localparam int REINIT_NS      = 80;
    localparam int CLK_PERIOD_NS  = 10;
    localparam int REINIT_CYCLES  = (REINIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Transmit engine states
    typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_ACK} tx_state_type;
    // Reinit sequencer states
    typedef enum logic [1:0] {RI_RUN, RI_CLEAR, RI_DONE} ri_state_type;
endpackage
`default_nettype wire

// *** sim/serial_line_model.sv ***
`default_nettype none
// Serial line with pins 2 and 3 bridged: every byte sent comes back
module serial_line_model (
    input  wire logic       clk_sys,
    input  wire logic       reset,
    input  wire logic       slow,
    input  wire logic [7:0] tx_byte,
    input  wire logic       tx_valid,
    output logic            tx_ready,
    output logic      [7:0] rx_byte,
    output logic            rx_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic ph;  // Phase for the slow serialiser
    // Slow mode takes a byte only every other cycle, so the sender must stall
    assign tx_ready = !slow || ph;
    // Echo one cycle later; between bytes the data line shows junk, not the old byte
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ph       <= 1'b0;
            rx_valid <= 1'b0;
            rx_byte  <= 8'h00;
        end
        else
        begin
            ph       <= ~ph;
            rx_valid <= tx_valid && tx_ready;
            rx_byte  <= (tx_valid && tx_ready) ? tx_byte : ~rx_byte;
        end
    end
endmodule
`default_nettype wire

// *** sim/serial_handshake_props.sv ***
`default_nettype none
module serial_handshake_props (
    input wire logic        clk_sys,
    input wire logic        reset,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic [7:0]  tx_byte,
    input wire logic        tx_valid,
    input wire logic        tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    logic [15:0] ctl;     // Shadow of the control word
    logic [11:0] sent;    // Bytes taken since the last send toggle
    logic [3:0]  ri_cnt;  // Cycles with reinit held, saturating
    wire logic acc = psel && penable && pready;
    wire logic wr_ctl = acc && pwrite && paddr == serial_handshake_pkg::ADDR_CONTROL;
    wire logic rd_ctl = acc && !pwrite && paddr == serial_handshake_pkg::ADDR_CONTROL;
    wire logic rd_st = acc && !pwrite && paddr == serial_handshake_pkg::ADDR_STATUS;
    // Track what software asked for, since the block's registers are hidden
    always_ff @(posedge clk_sys or posedge reset)
    begin
        if (reset)
        begin
            ctl    <= 16'h0000;
            sent   <= 12'h000;
            ri_cnt <= 4'h0;
        end
        else
        begin
            ctl    <= wr_ctl ? pwdata[15:0] : ctl;
            sent   <= (wr_ctl && pwdata[0] != ctl[0]) ? 12'h000 :
                      sent + 12'((tx_valid && tx_ready) ? 1 : 0);
            ri_cnt <= !ctl[2] ? 4'h0 : (ri_cnt == 4'hF ? ri_cnt : ri_cnt + 4'h1);
        end
    end
    sequence tx_stall;
        tx_valid && !tx_ready;
    endsequence
    // Margin over the 8-cycle clear so the read never races completion
    done_set_a: assert property (rd_st && ri_cnt >= 4'd12 |-> prdata[2])
        else $error("reinit done not reported");
    done_clear_a: assert property (rd_st && ri_cnt == 0 && $past(ri_cnt, 3) == 0 |-> !prdata[2])
        else $error("reinit done still set");
    tx_block_a: assert property (ri_cnt >= 4'd3 |-> !tx_valid)
        else $error("sending during reinit");
    tx_start_a: assert property ($rose(tx_valid) |-> sent == 0)
        else $error("send started without toggle");
    tx_count_a: assert property (sent <= ctl[15:4])
        else $error("more bytes sent than asked");
    tx_hold_a: assert property (tx_stall |=> tx_valid && $stable(tx_byte))
        else $error("offered byte dropped");
    rx_len_a: assert property (rd_st |-> prdata[15:4] <= 12'(serial_handshake_pkg::FIFO_DEPTH)
        && prdata[31:16] == 16'h0000)
        else $error("status word out of range");
    ctl_back_a: assert property (rd_ctl |-> {prdata[15:4], prdata[2:0]} == {ctl[15:4], ctl[2:0]})
        else $error("control word readback wrong");
endmodule
bind serial_handshake serial_handshake_props props_i (.clk_sys, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .tx_byte, .tx_valid, .tx_ready);
`default_nettype wire

// *** sim/serial_handshake_bench.sv ***
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module serial_handshake_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys = 1'b0, reset = 1'b1, clk_en = 1'b1;  // Clock, reset, run enable
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;   // APB strobes
    logic [7:0]  paddr = 8'h00;                                  // APB address
    logic [31:0] pwdata = 32'h0, prdata, rd;                     // Write, read, last read
    logic        pready, pslverr, irq, tx_valid, tx_ready, rx_valid, slow = 1'b0;
    logic [7:0]  tx_byte, rx_byte;                               // Serial bytes
    logic [15:0] cw = 16'h0000;                                  // Control word we own
    logic        ta = 1'b0, rv = 1'b0;                           // Expected status toggles
    int          err_total = 0, num_checks = 0;
    always #5 clk_sys = ~clk_sys;
    serial_handshake uut (.clk_sys, .reset, .clk_en, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .irq, .tx_byte, .tx_valid, .tx_ready, .rx_byte, .rx_valid);
    serial_line_model line_i (.clk_sys, .reset, .slow, .tx_byte, .tx_valid, .tx_ready,
        .rx_byte, .rx_valid);
    // One APB transfer; request held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_sys);
        penable <= 1'b1;
        // No wait count is assumed; only the watchdog ends a stuck access
        do
            @(posedge clk_sys);
        while (pready !== 1'b1);
        rd = prdata;
        {psel, penable} <= 2'b00;
    endtask
    task expect_rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(rd & m, e)
    endtask
    // Poll the status word, bounded, until a bit takes the wanted value
    task wait_bit(input int b, input logic v);
        for (int n = 0; n < 100; n++)
        begin
            apb(1'b0, serial_handshake_pkg::ADDR_STATUS, 32'h0);
            if (rd[b] === v) break;
        end
        `CHK(rd[b], v)
    endtask
    task ctl_wr();
        apb(1'b1, serial_handshake_pkg::ADDR_CONTROL, {16'h0000, cw});
    endtask
    task ack();
        cw[1] = ~cw[1];
        ctl_wr();
    endtask
    // Fill the transmit array, flip the send toggle, wait for its echo
    task send(input int len, input logic [7:0] base);
        for (int i = 0; i < len; i++)
            apb(1'b1, serial_handshake_pkg::ADDR_TX_BASE + 8'(4 * i), {24'h0, base + 8'(i)});
        cw[15:4] = 12'(len);
        cw[0] = ~cw[0];
        ta = ~ta;
        ctl_wr();
        wait_bit(0, ta);
    endtask
    // A block may arrive in several copies; sum them and check every byte
    task collect(input int n, input logic [7:0] base);
        int got;
        int len;
        got = 0;
        for (int k = 0; k < 16 && got < n; k++)
        begin
            rv = ~rv;
            wait_bit(1, rv);
            apb(1'b0, serial_handshake_pkg::ADDR_STATUS, 32'h0);
            len = int'(rd[15:4]);
            for (int i = 0; i < len; i++)
            begin
                apb(1'b0, serial_handshake_pkg::ADDR_RX_BASE + 8'(4 * i), 32'h0);
                `CHK(rd[7:0], base + 8'(got + i))
            end
            got += len;
            ack();
        end
        `CHK(got, n)
    endtask
    task sc_regs();
        expect_rd(serial_handshake_pkg::ADDR_CONTROL, 32'hFFFFFFFF, 32'h0);
        expect_rd(serial_handshake_pkg::ADDR_STATUS, 32'hFFFFFFFF, 32'h0);
        apb(1'b1, 8'h20, 32'hFFFFFFFF);
        `CHK(pslverr, 1'b0)
        expect_rd(8'h20, 32'hFFFFFFFF, 32'h0);
    endtask
    // Slow line stalls the sender; tx done raises, clears and masks the interrupt
    task sc_loop();
        slow <= 1'b1;
        apb(1'b1, serial_handshake_pkg::ADDR_IRQ_MSK, 32'h1);
        send(3, 8'hA0);
        @(negedge clk_sys);
        `CHK(irq, 1'b1)
        apb(1'b1, serial_handshake_pkg::ADDR_IRQ_STS, 32'h1);
        @(negedge clk_sys);
        `CHK(irq, 1'b0)
        collect(3, 8'hA0);
        apb(1'b1, serial_handshake_pkg::ADDR_IRQ_MSK, 32'h0);
        slow <= 1'b0;
    endtask
    // Array held unacknowledged while 17 more bytes arrive: FIFO fills, one lost
    task sc_full();
        send(1, 8'h50);
        rv = ~rv;
        wait_bit(1, rv);
        send(16, 8'h60);
        send(1, 8'hEE);
        expect_rd(serial_handshake_pkg::ADDR_STATUS, 32'hFFF8, 32'h18);
        ack();
        collect(16, 8'h60);
        repeat (20) @(posedge clk_sys);
        expect_rd(serial_handshake_pkg::ADDR_STATUS, 32'hF, {30'h0, rv, ta});
    endtask
    // Reinit with data pending and a send toggle that must be ignored
    task sc_reinit();
        send(1, 8'h44);
        rv = ~rv;
        wait_bit(1, rv);
        cw[2] = 1'b1;
        cw[0] = ~cw[0];
        ctl_wr();
        wait_bit(2, 1'b1);
        expect_rd(serial_handshake_pkg::ADDR_STATUS, 32'hFFF3, 32'h0);
        cw[2] = 1'b0;
        ctl_wr();
        wait_bit(2, 1'b0);
        ta = 1'b0;
        rv = 1'b0;
        send(1, 8'h33);
        collect(1, 8'h33);
    endtask
    task wrap_up();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Whole run needs a few hundred cycles; 20000 means a hang
    initial
    begin
        #200us;
        err_total++;
        wrap_up();
    end
    initial
    begin
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        sc_regs();
        sc_loop();
        sc_full();
        sc_reinit();
        wrap_up();
    end
endmodule
`default_nettype wire
